// ---- gpt_pkg.sv ----
/*
  Shared constants of the general purpose timer block: register map,
  control field positions, write masks, reset values and prescaler terms.
  Assumes a 32-bit APB slave with one aligned word per register.
*/
package gpt_pkg;

  // timer slots: 0 first timer, 1/2 pair a low/high, 3/4 pair b low/high
  localparam int GPT_NUM_TMR = 5;
  localparam int GPT_CW      = 16;
  localparam int GPT_T_FIRST = 0;
  localparam int GPT_T_A_LO  = 1;
  localparam int GPT_T_A_HI  = 2;
  localparam int GPT_T_B_LO  = 3;
  localparam int GPT_T_B_HI  = 4;

  // byte offsets
  localparam logic [7:0] GPT_CTL_BASE = 8'h00;
  localparam logic [7:0] GPT_PER_BASE = 8'h14;
  localparam logic [7:0] GPT_CNT_BASE = 8'h28;
  localparam logic [7:0] GPT_FLAG_OFS = 8'h3C;
  localparam logic [7:0] GPT_MAP_LAST = 8'h3F;

  // control field positions
  localparam int GPT_RUN_BIT  = 15;
  localparam int GPT_IDLE_BIT = 13;
  localparam int GPT_GATE_BIT = 6;
  localparam int GPT_PS_MSB   = 5;
  localparam int GPT_PS_LSB   = 4;
  localparam int GPT_JOIN_BIT = 3;
  localparam int GPT_SYNC_BIT = 2;
  localparam int GPT_SRC_BIT  = 1;

  // implemented control bits per timer kind
  localparam logic [15:0] GPT_FIRST_MASK = 16'hA076;
  localparam logic [15:0] GPT_LOW_MASK   = 16'hA07A;
  localparam logic [15:0] GPT_HIGH_MASK  = 16'hA072;

  // reset values
  localparam logic [15:0] GPT_CTL_RST  = 16'h0000;
  localparam logic [15:0] GPT_PER_RST  = 16'hFFFF;
  localparam logic [15:0] GPT_CNT_RST  = 16'h0000;
  localparam logic [4:0]  GPT_FLAG_RST = 5'h00;

  // prescale codes in field order
  typedef enum logic [1:0] {GPT_PS_1, GPT_PS_8, GPT_PS_64, GPT_PS_256} gpt_ps_t;

  // last prescaler count before a tick
  localparam logic [7:0] GPT_DIV8_LAST   = 8'h07;
  localparam logic [7:0] GPT_DIV64_LAST  = 8'h3F;
  localparam logic [7:0] GPT_DIV256_LAST = 8'hFF;

endpackage

// ---- gpt_pin_sync.sv ----
/*
  Three-stage input synchroniser for one timer clock/gate pin, with
  accepted level and one-cycle rise and fall pulses.
  Assumes the pin is asynchronous to pclk.
*/
`timescale 1ns/1ns
module gpt_pin_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      rise_late,
  output logic      fall
);
  logic s1;
  logic s2;
  logic s3;
  logic agree;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign agree = (s2 == s3);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level     <= 1'b0;
      rise      <= 1'b0;
      fall      <= 1'b0;
      rise_late <= 1'b0;
    end else begin
      if (agree) begin
        level <= s3;
      end
      rise      <= agree & s3 & ~level;
      fall      <= agree & ~s3 & level;
      rise_late <= rise;
    end
  end
endmodule

// ---- gpt_prescaler.sv ----
/*
  Input clock prescaler: passes every 1st, 8th, 64th or 256th step pulse.
  Assumes step is a one-cycle pulse on pclk.
*/
`timescale 1ns/1ns
module gpt_prescaler
  import gpt_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clear,
  input  wire logic       step,
  input  wire logic [1:0] sel,
  output logic            tick
);
  logic [7:0] cnt;
  logic [7:0] last;

  always_comb begin
    case (gpt_ps_t'(sel))
      GPT_PS_8:   last = GPT_DIV8_LAST;
      GPT_PS_64:  last = GPT_DIV64_LAST;
      GPT_PS_256: last = GPT_DIV256_LAST;
      default:    last = 8'h00;
    endcase
  end

  assign tick = step & (cnt >= last);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
    end else if (clear || tick) begin
      cnt <= 8'h00;
    end else if (step) begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule

// ---- gpt_timers.sv ----
/*
  General purpose timer block: one 16-bit timer with synchronous and
  unsynchronised external counting, and two pairs of 16-bit timers that
  may join into 32-bit timers. Registers sit on an APB slave.
  Assumes idle_mode comes from logic on pclk; clock pins are asynchronous.
*/
// Added by the designer: the APB register port and the register offsets.
// Notes on behaviour
// - First timer: 16-bit timer, synchronous counter or unsynchronised counter.
// - First timer flags on period match or gate falling edge when gated.
// - Control bit 15 starts counting when one, stops when zero.
// - Bit 13 set halts timer in idle; clear keeps it counting.
// - Gate enable bit 6 works only with internal clock selected.
// - Prescale bits 5-4: 11 /256, 10 /64, 01 /8, 00 /1.
// - With external clock, bit 2 picks synchronised or unsynchronised counting.
// - Bit 1 picks external pin rising edges or internal half-rate clock.
// - Unimplemented control bits ignore writes and read zero.
// - Each pair is one 32-bit timer or two 16-bit timers.
// - Paired timers count synchronously only; no unsynchronised mode.
// - Joined pair uses low timer control, clock, gate; flag on high timer.
// - Low control bit 3 joins the pair into a 32-bit timer.
// - Joined period: high period register upper word, low period lower.
// - Joined count: high count register upper word, low count lower.
// - Joined pair flags when 32-bit count matches 32-bit period.
// - Only pair a high timer drives the converter trigger.
// - All timers may run in idle or sleep unless idle-halt set.
// - Joined pair is started and stopped by low timer run bit.
// - Paired timers use the same prescale encoding as the first.
`timescale 1ns/1ns
module gpt_timers
  import gpt_pkg::*;
#(
  parameter int APB_AW = 12
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              idle_mode,
  input  wire logic              first_timer_ext_clock_pin,
  input  wire logic [3:0]        paired_timer_ext_clock_pin,
  output logic      [4:0]        event_flag,
  output logic                   adc_trigger
);

  logic [15:0] ctl     [GPT_NUM_TMR];
  logic [15:0] per     [GPT_NUM_TMR];
  logic [15:0] cnt     [GPT_NUM_TMR];
  logic [15:0] next_cnt[GPT_NUM_TMR];

  logic [GPT_NUM_TMR-1:0] pin_in;
  logic [GPT_NUM_TMR-1:0] pin_level;
  logic [GPT_NUM_TMR-1:0] pin_rise;
  logic [GPT_NUM_TMR-1:0] pin_rise_late;
  logic [GPT_NUM_TMR-1:0] pin_fall;
  logic [GPT_NUM_TMR-1:0] run;
  logic [GPT_NUM_TMR-1:0] gate_en;
  logic [GPT_NUM_TMR-1:0] step;
  logic [GPT_NUM_TMR-1:0] tick;
  logic [GPT_NUM_TMR-1:0] ps_clear;
  logic [GPT_NUM_TMR-1:0] evt;
  logic [GPT_NUM_TMR-1:0] joined_lo;
  logic [GPT_NUM_TMR-1:0] joined_hi;
  logic [GPT_NUM_TMR-1:0] ctl_wr;
  logic [GPT_NUM_TMR-1:0] per_wr;
  logic [GPT_NUM_TMR-1:0] cnt_wr;
  logic [4:0]             flag_clr;
  logic                   half_en;

  // ---------------- APB decode ----------------
  logic [7:0]  ofs;
  logic        in_map;
  logic        hit;
  logic        wr_acc;
  logic        rd_setup;
  logic [2:0]  sel_k;
  logic [1:0]  sel_kind;
  logic [31:0] next_rdata;

  assign ofs      = paddr[7:0];
  assign in_map   = (paddr[APB_AW-1:8] == '0) && (ofs <= GPT_MAP_LAST);
  assign hit      = in_map;
  assign wr_acc   = psel & penable & pwrite & hit;
  assign rd_setup = psel & ~penable & ~pwrite;
  // zero wait states; unmapped addresses answer with an error
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~hit;

  // kind 0 control, 1 period, 2 count, 3 flags
  always_comb begin
    sel_kind = 2'd3;
    sel_k    = 3'd0;
    if (ofs >= GPT_FLAG_OFS) begin
      sel_kind = 2'd3;
    end else if (ofs >= GPT_CNT_BASE) begin
      sel_kind = 2'd2;
      sel_k    = 3'((ofs - GPT_CNT_BASE) >> 2);
    end else if (ofs >= GPT_PER_BASE) begin
      sel_kind = 2'd1;
      sel_k    = 3'((ofs - GPT_PER_BASE) >> 2);
    end else begin
      sel_kind = 2'd0;
      sel_k    = 3'((ofs - GPT_CTL_BASE) >> 2);
    end
  end

  always_comb begin
    ctl_wr   = '0;
    per_wr   = '0;
    cnt_wr   = '0;
    flag_clr = '0;
    if (wr_acc) begin
      case (sel_kind)
        2'd0:    ctl_wr[sel_k] = 1'b1;
        2'd1:    per_wr[sel_k] = 1'b1;
        2'd2:    cnt_wr[sel_k] = 1'b1;
        default: flag_clr      = pwdata[4:0];
      endcase
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (sel_kind)
      2'd0:    next_rdata[15:0] = ctl[sel_k];
      2'd1:    next_rdata[15:0] = per[sel_k];
      2'd2:    next_rdata[15:0] = cnt[sel_k];
      default: next_rdata[4:0]  = event_flag;
    endcase
  end

  // read data is captured in the setup cycle, valid in the access cycle
  // unmapped reads load zero so stale data of an earlier read never shows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      if (hit) begin
        prdata <= next_rdata;
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ---------------- control and period registers ----------------
  function automatic logic [15:0] ctl_mask(input int k);
    if (k == GPT_T_FIRST) begin
      ctl_mask = GPT_FIRST_MASK;
    end else if (k == GPT_T_A_LO || k == GPT_T_B_LO) begin
      ctl_mask = GPT_LOW_MASK;
    end else begin
      ctl_mask = GPT_HIGH_MASK;
    end
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < GPT_NUM_TMR; k++) begin
        ctl[k] <= GPT_CTL_RST;
      end
    end else begin
      for (int k = 0; k < GPT_NUM_TMR; k++) begin
        if (ctl_wr[k]) begin
          ctl[k] <= pwdata[15:0] & ctl_mask(k);
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < GPT_NUM_TMR; k++) begin
        per[k] <= GPT_PER_RST;
      end
    end else begin
      for (int k = 0; k < GPT_NUM_TMR; k++) begin
        if (per_wr[k]) begin
          per[k] <= pwdata[15:0];
        end
      end
    end
  end

  // ---------------- internal half-rate clock ----------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_en <= 1'b0;
    end else begin
      half_en <= ~half_en;
    end
  end

  // ---------------- pins, clock selection, prescalers ----------------
  assign pin_in = {paired_timer_ext_clock_pin, first_timer_ext_clock_pin};

  always_comb begin
    joined_lo = '0;
    joined_hi = '0;
    joined_lo[GPT_T_A_LO] = ctl[GPT_T_A_LO][GPT_JOIN_BIT];
    joined_hi[GPT_T_A_HI] = ctl[GPT_T_A_LO][GPT_JOIN_BIT];
    joined_lo[GPT_T_B_LO] = ctl[GPT_T_B_LO][GPT_JOIN_BIT];
    joined_hi[GPT_T_B_HI] = ctl[GPT_T_B_LO][GPT_JOIN_BIT];
  end

  genvar g;
  generate
    for (g = 0; g < GPT_NUM_TMR; g++) begin : g_tmr
      logic ext_step;

      gpt_pin_sync u_sync (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin       (pin_in[g]),
        .level     (pin_level[g]),
        .rise      (pin_rise[g]),
        .rise_late (pin_rise_late[g]),
        .fall      (pin_fall[g])
      );

      // halted by its own run bit or by idle when idle-halt is set
      assign run[g] = ctl[g][GPT_RUN_BIT]
                    & ~(ctl[g][GPT_IDLE_BIT] & idle_mode);

      // gating only applies with the internal clock selected
      assign gate_en[g] = ctl[g][GPT_GATE_BIT] & ~ctl[g][GPT_SRC_BIT];

      if (g == GPT_T_FIRST) begin : g_first
        // retimed path when sync selected, direct accepted edge otherwise
        assign ext_step = ctl[g][GPT_SYNC_BIT] ? pin_rise_late[g]
                                               : pin_rise[g];
      end else begin : g_pair
        assign ext_step = pin_rise_late[g];
      end

      assign step[g] = run[g] & (ctl[g][GPT_SRC_BIT] ? ext_step
                     : half_en & (~gate_en[g] | pin_level[g]));

      assign ps_clear[g] = ctl_wr[g] | cnt_wr[g];

      gpt_prescaler u_ps (
        .pclk    (pclk),
        .presetn (presetn),
        .clear   (ps_clear[g]),
        .step    (step[g]),
        .sel     (ctl[g][GPT_PS_MSB:GPT_PS_LSB]),
        .tick    (tick[g])
      );
    end
  endgenerate

  // ---------------- count update ----------------
  always_comb begin
    int hi;
    hi  = 0;
    evt = '0;
    for (int k = 0; k < GPT_NUM_TMR; k++) begin
      next_cnt[k] = cnt[k];
    end

    // stand-alone 16-bit timers
    for (int k = 0; k < GPT_NUM_TMR; k++) begin
      if (!joined_lo[k] && !joined_hi[k] && tick[k]) begin
        if (cnt[k] == per[k]) begin
          next_cnt[k] = 16'h0000;
          evt[k]      = 1'b1;
        end else begin
          next_cnt[k] = cnt[k] + 16'h0001;
        end
      end
    end

    // joined pairs: low slot drives, high slot carries the flag
    for (int lo = GPT_T_A_LO; lo < GPT_NUM_TMR; lo += 2) begin
      hi = lo + 1;
      if (joined_lo[lo] && tick[lo]) begin
        if ({cnt[hi], cnt[lo]} == {per[hi], per[lo]}) begin
          next_cnt[hi] = 16'h0000;
          next_cnt[lo] = 16'h0000;
          evt[hi]      = 1'b1;
        end else begin
          {next_cnt[hi], next_cnt[lo]} = {cnt[hi], cnt[lo]} + 32'h0000_0001;
        end
      end
    end

    // gate falling edge ends an accumulation interval
    // joined pair: low slot gate, flag raised on the high slot
    for (int k = 0; k < GPT_NUM_TMR; k++) begin
      if (!joined_hi[k] && run[k] && gate_en[k] && pin_fall[k]) begin
        if (joined_lo[k]) begin
          evt[k + 1] = 1'b1;
        end else begin
          evt[k] = 1'b1;
        end
      end
    end
  end

  // a software write to a count register wins over a counted step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < GPT_NUM_TMR; k++) begin
        cnt[k] <= GPT_CNT_RST;
      end
    end else begin
      for (int k = 0; k < GPT_NUM_TMR; k++) begin
        if (cnt_wr[k]) begin
          cnt[k] <= pwdata[15:0];
        end else begin
          cnt[k] <= next_cnt[k];
        end
      end
    end
  end

  // ---------------- event flags ----------------
  // a new event in the clearing cycle keeps the flag set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_flag <= GPT_FLAG_RST;
    end else begin
      event_flag <= (event_flag & ~flag_clr) | evt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_trigger <= 1'b0;
    end else begin
      adc_trigger <= evt[GPT_T_A_HI];
    end
  end

endmodule

// ---- gpt_timers_asserts.sv ----
/*
  Port checker for the timer block: bus answers, control read masks,
  sticky event flags and converter trigger timing.
  Assumes one pclk domain; bound into gpt_timers.
*/
`timescale 1ns/1ns
module gpt_timers_asserts
  import gpt_pkg::*;
#(
  parameter int APB_AW = 12
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              idle_mode,
  input wire logic              first_timer_ext_clock_pin,
  input wire logic [3:0]        paired_timer_ext_clock_pin,
  input wire logic [4:0]        event_flag,
  input wire logic              adc_trigger
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_rd;
    psel && penable && !pwrite;
  endsequence
  sequence s_rd_at(logic [7:0] a0, logic [7:0] a1);
    s_rd ##0 (paddr[7:0] == a0 || paddr[7:0] == a1);
  endsequence

  property p_upper;
    s_rd |-> prdata[31:16] == 16'h0;
  endproperty
  property p_first_mask;
    s_rd_at(8'h00, 8'h00) |-> (prdata[15:0] & ~GPT_FIRST_MASK) == 16'h0;
  endproperty
  property p_low_mask;
    s_rd_at(8'h04, 8'h0C) |-> (prdata[15:0] & ~GPT_LOW_MASK) == 16'h0;
  endproperty
  property p_high_mask;
    s_rd_at(8'h08, 8'h10) |-> (prdata[15:0] & ~GPT_HIGH_MASK) == 16'h0;
  endproperty
  property p_err;
    psel && penable |-> pready && pslverr == (paddr >= 64);
  endproperty
  property p_err_data;
    s_rd ##0 pslverr |-> prdata == 32'h0;
  endproperty
  property p_sticky;
    !(psel && penable && pwrite && paddr[7:0] == GPT_FLAG_OFS)
      |=> (event_flag & $past(event_flag)) == $past(event_flag);
  endproperty
  property p_adc_follow;
    $rose(event_flag[2]) |-> adc_trigger;
  endproperty
  property p_adc_src;
    adc_trigger |-> event_flag[2];
  endproperty
  property p_adc_pulse;
    adc_trigger |=> !adc_trigger;
  endproperty

  a_upper: assert property (p_upper) else $error("read upper half not zero");
  a_first_mask: assert property (p_first_mask) else $error("first control bad bit");
  a_low_mask: assert property (p_low_mask) else $error("low control bad bit");
  a_high_mask: assert property (p_high_mask) else $error("high control bad bit");
  a_err: assert property (p_err) else $error("slave error or ready wrong");
  a_err_data: assert property (p_err_data) else $error("unmapped read not zero");
  a_sticky: assert property (p_sticky) else $error("event flag dropped");
  a_adc_follow: assert property (p_adc_follow) else $error("trigger missing");
  a_adc_src: assert property (p_adc_src) else $error("trigger without event");
  a_adc_pulse: assert property (p_adc_pulse) else $error("trigger too long");
endmodule

bind gpt_timers gpt_timers_asserts #(.APB_AW(APB_AW)) i_gpt_timers_asserts (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .idle_mode, .first_timer_ext_clock_pin, .paired_timer_ext_clock_pin,
  .event_flag, .adc_trigger
);

// ---- gpt_pin_model.sv ----
/*
  Model of the external clock and gate pins of the timer block.
  Assumes calls start just after a rising pclk edge.
*/
`timescale 1ns/1ns
module gpt_pin_model (
  input  wire logic pclk,
  output logic       first_timer_ext_clock_pin,
  output logic [3:0] paired_timer_ext_clock_pin
);
  initial begin
    first_timer_ext_clock_pin = 1'h0;
    paired_timer_ext_clock_pin = 4'h0;
  end

  // id 0 first timer, 1..4 paired pins; level kept 4 edges, above the 2 needed
  task automatic drive(input int id, input logic lvl);
    if (id == 0) begin
      first_timer_ext_clock_pin <= lvl;
    end else begin
      paired_timer_ext_clock_pin[id-1] <= lvl;
    end
    repeat (4) @(posedge pclk);
  endtask

  task automatic pulse(input int id);
    drive(id, 1'h1);
    drive(id, 1'h0);
  endtask
endmodule

// ---- gpt_timers_bench.sv ----
/*
  Self-checking bench for the timer block over APB.
  Assumes the pin model drives the external clock and gate pins.
*/
`timescale 1ns/1ns
module gpt_timers_bench
  import gpt_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, idle_mode, pready, pslverr;
  logic        adc_trigger, first_timer_ext_clock_pin, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  paired_timer_ext_clock_pin;
  logic [4:0]  event_flag;
  int          n_mismatch, total_checks, cyc, n, c, s;

  gpt_timers i_gpt_timers (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .idle_mode, .first_timer_ext_clock_pin, .paired_timer_ext_clock_pin,
    .event_flag, .adc_trigger
  );
  gpt_pin_model i_gpt_pin_model (.pclk, .first_timer_ext_clock_pin, .paired_timer_ext_clock_pin);

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input int a, input logic [31:0] d);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= 12'(a);
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rdat = prdata;
    err  = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  task automatic wr(input int a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask

  task automatic rdc(input int a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rdat, e);
  endtask

  // stop, load period, zero count, clear flags, then start
  task automatic setup(input int t, input logic [31:0] per, input logic [31:0] ctl);
    wr(GPT_CTL_BASE + 4 * t, 32'h0);
    wr(GPT_PER_BASE + 4 * t, per);
    wr(GPT_CNT_BASE + 4 * t, 32'h0);
    wr(GPT_FLAG_OFS, 32'h1F);
    wr(GPT_CTL_BASE + 4 * t, ctl);
  endtask

  task automatic wait_bit(input int b);
    n = 0;
    while (event_flag[b] !== 1'h1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
  endtask

  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, idle_mode} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    for (int t = 0; t < 5; t++) begin
      rdc(GPT_CTL_BASE + 4 * t, 32'h0);
      rdc(GPT_PER_BASE + 4 * t, 32'hFFFF);
      rdc(GPT_CNT_BASE + 4 * t, 32'h0);
      wr(GPT_CTL_BASE + 4 * t, 32'h7FFF);
      rdc(GPT_CTL_BASE + 4 * t, t == 0 ? 32'h2076 : t % 2 ? 32'h207A : 32'h2072);
      wr(GPT_CTL_BASE + 4 * t, 32'h0);
    end
    rdc(12'h40, 32'h0);
    chk(err, 32'h1);
    for (int t = 0; t < 5; t++) begin
      for (int p = 0; p < 4; p++) begin
        setup(t, 32'h1, 32'h8000 | (p << 4));
        wait_bit(t);
        c = p == 3 ? 1024 : 4 << (3 * p);
        chk(32'(n >= c - 4 && n <= c + 2), 32'h1);
        wr(GPT_CTL_BASE + 4 * t, 32'h0);
        apb(1'h0, GPT_CNT_BASE + 4 * t, 32'h0);
        c = rdat;
        repeat (10) @(posedge pclk);
        rdc(GPT_CNT_BASE + 4 * t, c);
      end
    end
    for (int h = 0; h < 2; h++) begin
      setup(0, 32'hFFFF, 32'h8000 | (h << 13));
      idle_mode <= 1'h1;
      apb(1'h0, GPT_CNT_BASE, 32'h0);
      c = rdat;
      repeat (10) @(posedge pclk);
      apb(1'h0, GPT_CNT_BASE, 32'h0);
      chk(32'(rdat == c), 32'(h));
      idle_mode <= 1'h0;
    end
    for (int k = 0; k < 3; k++) begin
      s = k == 2 ? 3 : 0;
      setup(s, 32'h2, 32'h8042 | ((k % 2) << 2));
      i_gpt_pin_model.pulse(s);
      i_gpt_pin_model.pulse(s);
      repeat (8) @(posedge pclk);
      rdc(GPT_CNT_BASE + 4 * s, 32'h2);
      chk(event_flag[s], 32'h0);
      i_gpt_pin_model.pulse(s);
      repeat (8) @(posedge pclk);
      chk(event_flag[s], 32'h1);
    end
    setup(0, 32'hFFFF, 32'h8040);
    repeat (10) @(posedge pclk);
    rdc(GPT_CNT_BASE, 32'h0);
    i_gpt_pin_model.drive(0, 1'h1);
    repeat (20) @(posedge pclk);
    i_gpt_pin_model.drive(0, 1'h0);
    repeat (8) @(posedge pclk);
    chk(event_flag[0], 32'h1);
    apb(1'h0, GPT_CNT_BASE, 32'h0);
    chk(32'(rdat > 4 && rdat < 20), 32'h1);
    for (int q = 1; q < 4; q += 2) begin
      wr(GPT_CTL_BASE + 4 * q + 4, 32'h30);
      wr(GPT_PER_BASE + 4 * q + 4, 32'h1);
      wr(GPT_CNT_BASE + 4 * q + 4, 32'h1);
      setup(q, 32'h1, 32'h8008);
      wait_bit(q + 1);
      chk(adc_trigger, 32'(q == 1));
      chk(32'(n < 10), 32'h1);
      chk(event_flag[q], 32'h0);
      wr(GPT_CTL_BASE + 4 * q, 32'h0);
      wr(GPT_PER_BASE + 4 * q + 4, 32'hFFFF);
      wr(GPT_CNT_BASE + 4 * q + 4, 32'h0);
      wr(GPT_CNT_BASE + 4 * q, 32'hFFFF);
      wr(GPT_CTL_BASE + 4 * q, 32'h8008);
      repeat (6) @(posedge pclk);
      wr(GPT_CTL_BASE + 4 * q, 32'h0);
      rdc(GPT_CNT_BASE + 4 * q + 4, 32'h1);
    end
    summarize();
  end
endmodule
